// >>> bench/pdis_pse_model.sv
// Sourcing equipment model: port voltage and charge levels
`timescale 1ns/10ps
`default_nettype none
module pdis_pse_model (
  input  wire logic aclk,
  output var  logic class_done,
  output var  logic above_upper_uv,
  output var  logic below_reset_v,
  output var  logic return_node_low,
  output var  logic gate_high
);
  initial begin
    class_done = 1'b0;
    above_upper_uv = 1'b0;
    below_reset_v = 1'b1;
    return_node_low = 1'b0;
    gate_high = 1'b0;
  end
  task automatic grant();
    @(posedge aclk);
    class_done <= 1'b1;
    @(posedge aclk);
    above_upper_uv <= 1'b1;
    below_reset_v <= 1'b0;
  endtask
  task automatic charge(input logic v);
    @(posedge aclk);
    return_node_low <= v;
    gate_high <= v;
  endtask
  // Cable pulled, voltage under reset level
  task automatic remove();
    @(posedge aclk);
    class_done <= 1'b0;
    above_upper_uv <= 1'b0;
    below_reset_v <= 1'b1;
    return_node_low <= 1'b0;
    gate_high <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> bench/pdis_top_props.sv
// Port-level assertions for the inrush sequencer block
`timescale 1ns/10ps
`default_nettype none
module pdis_top_chk #(
  parameter int unsigned OC_CYCLES = 20
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic class_done,
  input  wire logic above_upper_uv,
  input  wire logic return_node_low,
  input  wire logic gate_high,
  input  wire logic output_short,
  input  wire logic over_current,
  input  wire logic pass_on,
  input  wire logic inrush_limit,
  input  wire logic power_good_out_o,
  input  wire logic power_good_out_oe_n,
  input  wire logic class_result_mid_oe_n,
  input  wire logic class_result_low_oe_n,
  input  wire logic pse_type_flag_o,
  input  wire logic pse_type_flag_oe_n
);
  // ---------------------
  // Overcurrent dwell
  // ---------------------
  int unsigned oc_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || !(over_current && pass_on && !inrush_limit)) begin
      oc_cnt <= 0;
    end else begin
      oc_cnt <= oc_cnt + 1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Five samples cover the synchroniser plus the output register
  sequence class_gone_s;
    !class_done [*5];
  endsequence
  sequence inrush_end_s;
    $fell(inrush_limit) && pass_on;
  endsequence
  inrush_entry_a: assert property (
    $rose(above_upper_uv) && class_done |-> ##[2:8] inrush_limit)
    else $error("inrush not entered");
  inrush_exit_a: assert property (
    inrush_end_s |-> $past(return_node_low, 2) && $past(gate_high, 2))
    else $error("inrush left without charge done");
  short_abort_a: assert property (
    inrush_limit && output_short |-> ##[1:6] !pass_on)
    else $error("short did not abort inrush");
  pg_low_a: assert property (
    inrush_limit |-> !power_good_out_oe_n && !power_good_out_o)
    else $error("power good not low in inrush");
  pg_release_a: assert property (
    !inrush_limit |-> power_good_out_oe_n)
    else $error("power good driven outside inrush");
  class_float_a: assert property (
    class_gone_s |-> class_result_mid_oe_n && class_result_low_oe_n)
    else $error("class pins driven without class");
  pse_float_a: assert property (
    class_gone_s |-> pse_type_flag_oe_n)
    else $error("type flag driven without class");
  pse_low_a: assert property (
    !pse_type_flag_oe_n |-> !pse_type_flag_o)
    else $error("type flag driven high");
  oc_trip_a: assert property (
    oc_cnt <= OC_CYCLES + 5)
    else $error("overcurrent did not trip");
endmodule
bind pdis_top pdis_top_chk #(.OC_CYCLES(OC_CYCLES)) u_chk (
  .aclk, .aresetn, .class_done, .above_upper_uv, .return_node_low,
  .gate_high, .output_short, .over_current, .pass_on, .inrush_limit,
  .power_good_out_o, .power_good_out_oe_n, .class_result_mid_oe_n,
  .class_result_low_oe_n, .pse_type_flag_o, .pse_type_flag_oe_n);
`default_nettype wire

// >>> bench/tb_pdis_top.sv
// Self-checking bench for the inrush sequencer block
`timescale 1ns/10ps
`default_nettype none
module tb_pdis_top;
  localparam int unsigned OC = 20;
  logic        aclk, aresetn, output_short, over_current, pg_wire;
  logic        class_done, above_upper_uv, below_reset_v;
  logic        return_node_low, gate_high, pass_on, inrush_limit;
  logic        power_good_out_o, power_good_out_oe_n;
  logic        class_result_mid_o, class_result_mid_oe_n;
  logic        class_result_low_o, class_result_low_oe_n;
  logic        pse_type_flag_o, pse_type_flag_oe_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cyc = 0;
  // Board pull-up on the power-good line
  assign pg_wire = power_good_out_oe_n ? 1'b1 : power_good_out_o;
  pdis_top #(.OC_CYCLES(OC)) dut (
    .aclk, .aresetn, .class_done, .above_upper_uv, .below_reset_v,
    .return_node_low, .gate_high, .output_short, .over_current, .pass_on,
    .inrush_limit, .power_good_out_o, .power_good_out_oe_n,
    .class_result_mid_o, .class_result_mid_oe_n, .class_result_low_o,
    .class_result_low_oe_n, .pse_type_flag_o, .pse_type_flag_oe_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  pdis_pse_model pse (.aclk, .class_done, .above_upper_uv, .below_reset_v,
    .return_node_low, .gate_high);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // ---------------------
  // Hang guard
  // ---------------------
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(pdis_pkg::RESP_OKAY), 32'(s_axi_bresp));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string n);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(n, e, d & m);
    chk("rresp", 32'(pdis_pkg::RESP_OKAY), 32'(r));
  endtask
  task automatic wait_lim(input logic v);
    for (int i = 0; i < 100 && inrush_limit !== v; i++) @(posedge aclk);
  endtask
  task automatic wait_pass(input logic v);
    for (int i = 0; i < 100 && pass_on !== v; i++) @(posedge aclk);
  endtask
  // ---------------------
  // System side
  // ---------------------
  localparam int KA_ON_OPEN_MS = 75;
  localparam int KA_ON_LOW_MS  = 7;
  localparam int KA_LO_MA      = 10;
  localparam int KA_HI_MA      = 16;
  // Open-drain levels pass two flops before use
  logic [3:0]  sys_meta = 4'h0;
  logic [3:0]  sys_sync = 4'h0;
  always @(posedge aclk) begin
    sys_meta <= {pg_wire, class_result_mid_oe_n, class_result_low_oe_n,
                 pse_type_flag_oe_n};
    sys_sync <= sys_meta;
  end
  // Requests below 4 taken as is; from 4 start at Class 3, raise only as the pins allow
  // Load is held inside the class decoded here
  function automatic int sys_class(input int req, input logic mid_open,
                                   input logic low_open);
    sys_class = 3;
    if (req < 4) sys_class = req;
    else if (mid_open) sys_class = low_open ? 3 : 4;
    else if (req <= 6 || !low_open) sys_class = req;
    else sys_class = 6;
  endfunction
  // Keep-alive on time chosen by the type flag
  function automatic int sys_ka_on(input logic flag_open);
    sys_ka_on = flag_open ? KA_ON_OPEN_MS : KA_ON_LOW_MS;
  endfunction
  // Keep-alive threshold from requested and assigned class
  function automatic int sys_ka_ma(input int req, input int cls);
    sys_ka_ma = (req >= 5 && cls >= 5) ? KA_HI_MA : KA_LO_MA;
  endfunction
  // Millisecond load and keep-alive steps exceed this run
  // ---------------------
  // Scenarios
  // ---------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rchk(pdis_pkg::OFS_ID, 32'hffffffff, pdis_pkg::BLOCK_ID, "id");
    rchk(pdis_pkg::OFS_CTRL, 32'h3, pdis_pkg::CTRL_RESET, "ctrl");
    rchk(pdis_pkg::OFS_CLASS, 32'hf, 32'(pdis_pkg::CLS_REQ_RESET), "cls");
    rd(8'h10, d, r);
    chk("unmapped", 32'(pdis_pkg::RESP_SLVERR), 32'(r));
  endtask
  task automatic t_start();
    int cls;
    wr(pdis_pkg::OFS_CLASS, 32'h18);
    pse.grant();
    wait_lim(1'b1);
    chk("pg inrush", 32'h0, 32'(pg_wire));
    chk("pass inrush", 32'h1, 32'(pass_on));
    rchk(pdis_pkg::OFS_STATUS, 32'h7, 32'h1, "st inrush");
    pse.charge(1'b1);
    wait_lim(1'b0);
    chk("pg normal", 32'h1, 32'(pg_wire));
    chk("pass normal", 32'h1, 32'(pass_on));
    rchk(pdis_pkg::OFS_STATUS, 32'h7, 32'h2, "st normal");
    chk("cls pins", 32'h0, 32'({class_result_mid_oe_n,
                                class_result_low_oe_n}));
    chk("flag low", 32'h0, 32'(pse_type_flag_oe_n));
    chk("pg sync", 32'h1, 32'(sys_sync[3]));
    cls = sys_class(8, sys_sync[2], sys_sync[1]);
    chk("cls dec", 32'h8, 32'(cls));
    chk("ka on", 32'h7, 32'(sys_ka_on(sys_sync[0])));
    chk("ka ma", 32'h10, 32'(sys_ka_ma(8, cls)));
  endtask
  task automatic t_oc();
    chk("load gate", 32'h1, 32'(sys_sync[3]));
    @(posedge aclk);
    over_current <= 1'b1;
    repeat (OC) @(posedge aclk);
    chk("oc early", 32'h1, 32'(pass_on));
    wait_pass(1'b0);
    chk("oc trip", 32'h0, 32'(pass_on));
    over_current <= 1'b0;
    repeat (20) @(posedge aclk);
    chk("oc stay", 32'h0, 32'(pass_on));
    wr(pdis_pkg::OFS_CTRL, 32'h3);
    repeat (6) @(posedge aclk);
    chk("oc hold", 32'h0, 32'(pass_on));
    rchk(pdis_pkg::OFS_STATUS, 32'h87, 32'h83, "st trip");
    rchk(pdis_pkg::OFS_STATUS, 32'h87, 32'h03, "st clr");
    pse.remove();
    // Synchroniser plus state update before the idle read
    repeat (4) @(posedge aclk);
    rchk(pdis_pkg::OFS_STATUS, 32'h7, 32'h0, "st idle");
  endtask
  task automatic t_short();
    wr(pdis_pkg::OFS_CLASS, 32'h04);
    pse.grant();
    wait_lim(1'b1);
    chk("flag float", 32'h1, 32'(pse_type_flag_oe_n));
    chk("cls4 pins", 32'h0, 32'({class_result_mid_oe_n,
                                 class_result_low_oe_n}));
    @(posedge aclk);
    output_short <= 1'b1;
    wait_pass(1'b0);
    chk("short off", 32'h0, 32'(pass_on));
    chk("short pg", 32'h1, 32'(pg_wire));
    output_short <= 1'b0;
    rchk(pdis_pkg::OFS_STATUS, 32'h47, 32'h43, "st short");
    wr(pdis_pkg::OFS_CTRL, 32'h3);
    wait_lim(1'b1);
    chk("restart", 32'h1, 32'(inrush_limit));
    pse.remove();
    wait_pass(1'b0);
  endtask
  initial begin
    aresetn = 1'b0;
    output_short = 1'b0;
    over_current = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_start();
    t_oc();
    t_short();
    test_done();
  end
endmodule
`default_nettype wire

// >>> design/pdis_pkg.sv
// Shared constants for the PD inrush, start-up and status block
package pdis_pkg;

  localparam int unsigned CLK_HZ = 50000000;

  // Overcurrent timeout, microseconds
  localparam int unsigned OC_TIMEOUT_US = 960;
  localparam int unsigned OC_TIMEOUT_CYC =
    (OC_TIMEOUT_US * (CLK_HZ / 1000000) > 0) ?
    OC_TIMEOUT_US * (CLK_HZ / 1000000) : 1;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CLASS  = 8'h08;
  localparam logic [7:0] OFS_ID     = 8'h0c;

  // Control bits
  localparam int unsigned CTRL_ENABLE = 0;
  localparam int unsigned CTRL_RESTART = 1;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;

  // Class result encoding: requested class in [3:0], pse type 3/4 in [4]
  localparam int unsigned CLS_REQ_LSB = 0;
  localparam int unsigned CLS_REQ_W   = 4;
  localparam int unsigned CLS_T34_BIT = 4;
  localparam logic [3:0] CLS_REQ_RESET = 4'h8;

  // Arbitrary identity value
  localparam logic [31:0] BLOCK_ID = 32'h5a5a0001;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    PDIS_IDLE,
    PDIS_INRUSH,
    PDIS_NORMAL,
    PDIS_OFFLINE
  } pdis_state_e;

endpackage

// >>> design/pdis_sync.sv
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none

module pdis_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      dout     <= '0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// >>> design/pdis_top.sv
// Inrush sequencing, power-good, class result and PSE-type outputs
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Enter inrush once port voltage exceeds upper threshold after class.
// - Leave inrush for normal only when return node below 0.8 V and gate above 8.5 V.
// - An output short aborts inrush to protect the pass switch.
// - Power-good is driven low during the whole inrush state.
// - After inrush power-good floats; pass switch stays on, unlimited.
// - Requests 4-8: both open is Class 3, mid open low low is Class 4.
// - Mid low: 4-6 give request; 7/8 give 6 if low open, else request.
// - PSE-type output floats for type 1/2, driven low for type 3/4.
// - Overcurrent for 960 us disables switch; offline until reset voltage.
module pdis_top #(
  parameter int unsigned OC_CYCLES = pdis_pkg::OC_TIMEOUT_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Analog comparator pins
  input  wire logic        class_done,
  input  wire logic        above_upper_uv,
  input  wire logic        below_reset_v,
  input  wire logic        return_node_low,
  input  wire logic        gate_high,
  input  wire logic        output_short,
  input  wire logic        over_current,
  // Pass switch control
  output logic             pass_on,
  output logic             inrush_limit,
  // Open-drain outputs: level is low, oe_n low while driving
  output logic             power_good_out_o,
  output logic             power_good_out_oe_n,
  output logic             class_result_mid_o,
  output logic             class_result_mid_oe_n,
  output logic             class_result_low_o,
  output logic             class_result_low_oe_n,
  output logic             pse_type_flag_o,
  output logic             pse_type_flag_oe_n,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] pins_s;
  logic       cls_s, uv_s, rst_s, rtn_s, gate_s, short_s, oc_s;

  pdis_sync #(.WIDTH(7)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({class_done, above_upper_uv, below_reset_v, return_node_low,
               gate_high, output_short, over_current}),
    .dout    (pins_s)
  );

  assign {cls_s, uv_s, rst_s, rtn_s, gate_s, short_s, oc_s} = pins_s;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [4:0]  cls_cfg_reg;
  logic        restart_pulse;
  logic        short_seen_reg;
  logic        oc_seen_reg;
  logic        oc_lock_reg;

  // ----------------------------------------------------------------
  // Class decode
  // ----------------------------------------------------------------
  // Returns {mid_low, low_low}
  function automatic logic [1:0] cls_drive(input logic [3:0] req);
    cls_drive = 2'b00;
    case (req)
      4'h4, 4'h5, 4'h6, 4'h7, 4'h8: cls_drive = 2'b11;
      default: cls_drive = 2'b00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  pdis_pkg::pdis_state_e state_reg;
  logic [$clog2(OC_CYCLES+1)-1:0] oc_cnt_reg;
  logic oc_expired;

  assign oc_expired = (oc_cnt_reg >= OC_CYCLES[$clog2(OC_CYCLES+1)-1:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= pdis_pkg::PDIS_IDLE;
    end else begin
      case (state_reg)
        pdis_pkg::PDIS_IDLE: begin
          if (ctrl_reg[pdis_pkg::CTRL_ENABLE] && cls_s && uv_s) begin
            state_reg <= pdis_pkg::PDIS_INRUSH;
          end
        end
        pdis_pkg::PDIS_INRUSH: begin
          if (short_s || !uv_s) begin
            state_reg <= pdis_pkg::PDIS_OFFLINE;
          end else if (rtn_s && gate_s) begin
            state_reg <= pdis_pkg::PDIS_NORMAL;
          end
        end
        pdis_pkg::PDIS_NORMAL: begin
          if (oc_expired || !uv_s) begin
            state_reg <= pdis_pkg::PDIS_OFFLINE;
          end
        end
        pdis_pkg::PDIS_OFFLINE: begin
          // wait for reset voltage
          // Software restart cannot skip an overcurrent lockout
          if (rst_s || (restart_pulse && !oc_lock_reg)) begin
            state_reg <= pdis_pkg::PDIS_IDLE;
          end
        end
        default: state_reg <= pdis_pkg::PDIS_IDLE;
      endcase
    end
  end

  // Overcurrent filter counts only in normal operation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_cnt_reg <= '0;
    end else if (state_reg == pdis_pkg::PDIS_NORMAL && oc_s) begin
      if (!oc_expired) begin
        oc_cnt_reg <= oc_cnt_reg + 1'b1;
      end
    end else begin
      oc_cnt_reg <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  logic [1:0] drv;
  assign drv = cls_drive(cls_cfg_reg[pdis_pkg::CLS_REQ_LSB +:
                                     pdis_pkg::CLS_REQ_W]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pass_on               <= 1'b0;
      inrush_limit          <= 1'b0;
      power_good_out_o      <= 1'b0;
      power_good_out_oe_n   <= 1'b1;
      class_result_mid_o    <= 1'b0;
      class_result_mid_oe_n <= 1'b1;
      class_result_low_o    <= 1'b0;
      class_result_low_oe_n <= 1'b1;
      pse_type_flag_o       <= 1'b0;
      pse_type_flag_oe_n    <= 1'b1;
    end else begin
      // switch fully on, no limiting after inrush
      pass_on      <= (state_reg == pdis_pkg::PDIS_INRUSH) ||
                      (state_reg == pdis_pkg::PDIS_NORMAL);
      inrush_limit <= (state_reg == pdis_pkg::PDIS_INRUSH);
      // power-good held low in inrush, floats otherwise
      power_good_out_oe_n <= (state_reg != pdis_pkg::PDIS_INRUSH);
      class_result_mid_oe_n <= !(cls_s && drv[1]);
      class_result_low_oe_n <= !(cls_s && drv[0]);
      pse_type_flag_oe_n <= !(cls_s && cls_cfg_reg[pdis_pkg::CLS_T34_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [7:0]  aw_addr_reg;
  logic        aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_have_reg;
  logic        do_write;

  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      aw_addr_reg   <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg   <= 1'b0;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_reg && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // Write effects and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg      <= pdis_pkg::CTRL_RESET;
      cls_cfg_reg   <= {1'b0, pdis_pkg::CLS_REQ_RESET};
      restart_pulse <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pdis_pkg::RESP_OKAY;
    end else begin
      restart_pulse <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= pdis_pkg::RESP_OKAY;
        case (aw_addr_reg)
          pdis_pkg::OFS_CTRL: begin
            if (w_strb_reg[0]) begin
              ctrl_reg[pdis_pkg::CTRL_ENABLE] <=
                w_data_reg[pdis_pkg::CTRL_ENABLE];
              restart_pulse <= w_data_reg[pdis_pkg::CTRL_RESTART];
            end
          end
          pdis_pkg::OFS_CLASS: begin
            if (w_strb_reg[0]) begin
              cls_cfg_reg <= w_data_reg[4:0];
            end
          end
          pdis_pkg::OFS_STATUS, pdis_pkg::OFS_ID: begin
          end
          default: s_axi_bresp <= pdis_pkg::RESP_SLVERR;
        endcase
      end
    end
  end

  // Sticky event flags, set wins over clear-on-read
  logic rd_status;
  assign rd_status = s_axi_arvalid && s_axi_arready &&
                     s_axi_araddr == pdis_pkg::OFS_STATUS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      short_seen_reg <= 1'b0;
      oc_seen_reg    <= 1'b0;
      oc_lock_reg    <= 1'b0;
    end else begin
      if (state_reg == pdis_pkg::PDIS_NORMAL && oc_expired) begin
        oc_lock_reg <= 1'b1;
      end else if (state_reg == pdis_pkg::PDIS_IDLE) begin
        oc_lock_reg <= 1'b0;
      end
      if (state_reg == pdis_pkg::PDIS_INRUSH && short_s) begin
        short_seen_reg <= 1'b1;
      end else if (rd_status) begin
        short_seen_reg <= 1'b0;
      end
      if (state_reg == pdis_pkg::PDIS_NORMAL && oc_expired) begin
        oc_seen_reg <= 1'b1;
      end else if (rd_status) begin
        oc_seen_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= pdis_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= pdis_pkg::RESP_OKAY;
        case (s_axi_araddr)
          pdis_pkg::OFS_CTRL:   s_axi_rdata <= ctrl_reg;
          pdis_pkg::OFS_STATUS: s_axi_rdata <=
            {24'h000000, oc_seen_reg, short_seen_reg, uv_s, cls_s,
             1'b0, state_reg};
          pdis_pkg::OFS_CLASS:  s_axi_rdata <= {27'h0000000, cls_cfg_reg};
          pdis_pkg::OFS_ID:     s_axi_rdata <= pdis_pkg::BLOCK_ID;
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= pdis_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire
